// [rtl/dctp_pkg.sv]
// Package for the down-count timer/PWM: register map, field codes, state encodings.
// Assumes a single 25 MHz clock domain and an APB slave with 32-bit data.
// Operation
// - Sixteen-bit counter that only counts down on each selected clock edge.
// - Period is loaded on start, on reset input, and on terminal count.
// - Compare output true per selected relation: less, less-equal, equal, greater-equal, greater.
// - Interrupt may be raised on terminal count, compare true, or capture, each selectable.
// - Run configurations: free running, one shot, or gated by enable input.
// - One shot halts after one full period until started again.
// - Gated configuration decrements only in cycles where enable input is high.
// - Outputs: compare, terminal count or complementary compare, and interrupt request.
// - Capture input stores the full sixteen-bit count into a readable capture register.
// - Kill input forces comparator-derived outputs inactive while asserted.
// - Complementary PWM pair with deadband where neither output is active.
// - Counting clock is selected from several sources by configuration.
package dctp_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DB_W = 8;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_CAPTURE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_DEADBAND = 8'h1C;

  // Control register field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_MODE_LO = 1;
  localparam int unsigned CTRL_REL_LO = 3;
  localparam int unsigned CTRL_CLKSEL_LO = 6;
  localparam int unsigned CTRL_TCSEL = 8;
  localparam int unsigned CTRL_W = 9;

  localparam int unsigned ST_TC = 0;
  localparam int unsigned ST_CMP = 1;
  localparam int unsigned ST_CAP = 2;
  localparam int unsigned ST_W = 3;

  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] COMPARE_RST = 16'h8000;
  localparam logic [DB_W-1:0] DEADBAND_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DB_W-1:0] DB_ONE = 8'h01;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_GATED = 2'b10
  } dctp_mode_t;

  typedef enum logic [2:0] {
    cmp_less = 3'b000,
    cmp_less_or_equal = 3'b001,
    cmp_equal = 3'b010,
    cmp_greater_or_equal = 3'b011,
    cmp_greater = 3'b100
  } dctp_rel_t;

  typedef enum logic [1:0] {
    CLK_SYS = 2'b00,
    CLK_SRC1 = 2'b01,
    CLK_SRC2 = 2'b10,
    CLK_SRC3 = 2'b11
  } dctp_clksel_t;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_COUNT = 2'b01,
    RUN_DONE = 2'b10
  } dctp_run_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dctp_apb_req_t;

  typedef struct packed {
    logic enable;
    logic reset;
    logic capture;
    logic kill;
  } dctp_route_in_t;
endpackage : dctp_pkg

// [rtl/dctp_tick_sel.sv]
// Count-tick selector: turns one of several source levels into a one-cycle tick.
// Sources are synchronous to clock; a rising edge of the chosen source is a tick.
`timescale 1ns/1ps
`default_nettype none
module dctp_tick_sel #(
  parameter int unsigned NSRC = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [NSRC-1:0] srcIn,
  input wire dctp_pkg::dctp_clksel_t sel,
  output logic tick
);
  logic [NSRC-1:0] srcPrev_q;
  logic [NSRC:0] edges;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      srcPrev_q <= '0;
    end else begin
      srcPrev_q <= srcIn;
    end
  end

  // System clock always ticks; others tick on a rising edge
  assign edges[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gEdge
      assign edges[g+1] = srcIn[g] & ~srcPrev_q[g];
    end
  endgenerate

  assign tick = edges[sel];
endmodule : dctp_tick_sel
`default_nettype wire

// [rtl/dctp_deadband.sv]
// Deadband generator: splits one PWM level into a complementary pair.
// Delay counts are in count ticks; a zero length still leaves a one-cycle gap at each edge.
`timescale 1ns/1ps
`default_nettype none
module dctp_deadband #(
  parameter int unsigned DW = dctp_pkg::DB_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic pwmIn,
  input wire logic [DW-1:0] dbLen,
  output logic pwmHi,
  output logic pwmLo
);
  logic level_q;
  logic [DW-1:0] dbCnt_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
      dbCnt_q <= '0;
    end else if (pwmIn != level_q) begin
      level_q <= pwmIn;
      dbCnt_q <= dbLen;
    end else if (tick && dbCnt_q != '0) begin
      dbCnt_q <= dbCnt_q - DW'(1);
    end
  end

  // Both low while the gap runs, so the pair never overlaps
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwmHi <= 1'b0;
      pwmLo <= 1'b0;
    end else begin
      pwmHi <= level_q && dbCnt_q == '0 && pwmIn == level_q;
      pwmLo <= !level_q && dbCnt_q == '0 && pwmIn == level_q;
    end
  end

  chk_no_overlap: assert property (@(posedge clock) disable iff (!rst_b)
    !(pwmHi && pwmLo)) else $error("deadband pair overlaps");
endmodule : dctp_deadband
`default_nettype wire

// [rtl/dctp_timer.sv]
// Down-count timer/counter/PWM with an APB register slave and one interrupt line.
// Routing inputs (enable, reset, capture, kill, clock sources) are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module dctp_timer #(
  parameter int unsigned NSRC = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] clkSrc,
  input wire logic cntEnable,
  input wire logic cntReset,
  input wire logic capTrig,
  input wire logic killIn,
  output logic cmpOut,
  output logic tcOut,
  output logic pwmHi,
  output logic pwmLo,
  output logic irq
);
  dctp_pkg::dctp_apb_req_t apbReq;
  dctp_pkg::dctp_route_in_t rin;
  logic [dctp_pkg::CTRL_W-1:0] ctrl_q;
  logic [dctp_pkg::CNT_W-1:0] period_q;
  logic [dctp_pkg::CNT_W-1:0] compare_q;
  logic [dctp_pkg::CNT_W-1:0] count_q;
  logic [dctp_pkg::CNT_W-1:0] capture_q;
  logic [dctp_pkg::DB_W-1:0] deadband_q;
  logic [dctp_pkg::ST_W-1:0] status_q;
  logic [dctp_pkg::ST_W-1:0] mask_q;
  logic [dctp_pkg::ST_W-1:0] events;
  dctp_pkg::dctp_run_t run_q;
  logic capPrev_q;
  logic cmpPrev_q;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic startPulse;
  logic tick;
  logic countStep;
  logic atTerminal;
  logic tcEvent;
  logic capEvent;
  logic cmpTrue;
  logic cmpEvent;
  logic dbHi;
  logic dbLo;
  dctp_pkg::dctp_mode_t mode;
  dctp_pkg::dctp_rel_t rel;
  dctp_pkg::dctp_clksel_t clkSel;

  // All checks below run on the one system clock and sleep through reset
  default clocking cbClk @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  assign apbReq = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                    pwdata: pwdata};
  assign rin = '{enable: cntEnable, reset: cntReset, capture: capTrig, kill: killIn};

  assign mode = dctp_pkg::dctp_mode_t'(ctrl_q[dctp_pkg::CTRL_MODE_LO +: 2]);
  assign rel = dctp_pkg::dctp_rel_t'(ctrl_q[dctp_pkg::CTRL_REL_LO +: 3]);
  assign clkSel = dctp_pkg::dctp_clksel_t'(ctrl_q[dctp_pkg::CTRL_CLKSEL_LO +: 2]);

  // APB decode; the slave answers in the access cycle with no wait states
  always_comb begin
    addrOk = 1'b0;
    unique case (apbReq.paddr)
      dctp_pkg::ADDR_CTRL, dctp_pkg::ADDR_PERIOD, dctp_pkg::ADDR_COMPARE,
      dctp_pkg::ADDR_COUNT, dctp_pkg::ADDR_CAPTURE, dctp_pkg::ADDR_STATUS,
      dctp_pkg::ADDR_MASK, dctp_pkg::ADDR_DEADBAND: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && pready;
  assign rdEn = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  // Writing 1 to the start bit is a one-shot command and never reads back
  assign startPulse = wrEn && apbReq.paddr == dctp_pkg::ADDR_CTRL
                      && apbReq.pwdata[dctp_pkg::CTRL_START];

  // pready high during every access phase: registered high in setup
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbReq.psel && !apbReq.penable;
      pslverr <= apbReq.psel && !apbReq.penable && !addrOk;
    end
  end

  // Read data registered in setup so it is stable through the access phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= dctp_pkg::RD_ZERO;
    end else if (rdEn) begin
      prdata <= dctp_pkg::RD_ZERO;
      unique case (apbReq.paddr)
        dctp_pkg::ADDR_CTRL: prdata[dctp_pkg::CTRL_W-1:0] <= ctrl_q;
        dctp_pkg::ADDR_PERIOD: prdata[dctp_pkg::CNT_W-1:0] <= period_q;
        dctp_pkg::ADDR_COMPARE: prdata[dctp_pkg::CNT_W-1:0] <= compare_q;
        dctp_pkg::ADDR_COUNT: prdata[dctp_pkg::CNT_W-1:0] <= count_q;
        dctp_pkg::ADDR_CAPTURE: prdata[dctp_pkg::CNT_W-1:0] <= capture_q;
        dctp_pkg::ADDR_STATUS: prdata[dctp_pkg::ST_W-1:0] <= status_q;
        dctp_pkg::ADDR_MASK: prdata[dctp_pkg::ST_W-1:0] <= mask_q;
        dctp_pkg::ADDR_DEADBAND: prdata[dctp_pkg::DB_W-1:0] <= deadband_q;
        default: prdata <= dctp_pkg::RD_ZERO;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= '0;
      period_q <= dctp_pkg::PERIOD_RST;
      compare_q <= dctp_pkg::COMPARE_RST;
      mask_q <= '0;
      deadband_q <= dctp_pkg::DEADBAND_RST;
    end else if (wrEn) begin
      unique case (apbReq.paddr)
        dctp_pkg::ADDR_CTRL: begin
          ctrl_q <= apbReq.pwdata[dctp_pkg::CTRL_W-1:0];
          ctrl_q[dctp_pkg::CTRL_START] <= 1'b0;
        end
        dctp_pkg::ADDR_PERIOD: period_q <= apbReq.pwdata[dctp_pkg::CNT_W-1:0];
        dctp_pkg::ADDR_COMPARE: compare_q <= apbReq.pwdata[dctp_pkg::CNT_W-1:0];
        dctp_pkg::ADDR_MASK: mask_q <= apbReq.pwdata[dctp_pkg::ST_W-1:0];
        dctp_pkg::ADDR_DEADBAND: deadband_q <= apbReq.pwdata[dctp_pkg::DB_W-1:0];
        default: ;
      endcase
    end
  end

  dctp_tick_sel #(
    .NSRC(NSRC)
  ) uTick (
    .clock(clock),
    .rst_b(rst_b),
    .srcIn(clkSrc),
    .sel(clkSel),
    .tick(tick)
  );

  assign atTerminal = count_q == dctp_pkg::CNT_ZERO;
  // Gated mode steps only while enable is high
  assign countStep = tick && run_q == dctp_pkg::RUN_COUNT
                     && (mode != dctp_pkg::MODE_GATED || rin.enable);
  assign tcEvent = countStep && atTerminal;

  // Run state: free and gated run until rst_b; one shot parks after one period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= dctp_pkg::RUN_IDLE;
    end else if (startPulse) begin
      run_q <= dctp_pkg::RUN_COUNT;
    end else if (tcEvent && mode == dctp_pkg::MODE_ONESHOT) begin
      run_q <= dctp_pkg::RUN_DONE;
    end
  end

  // Down counter; reload wins over decrement
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= dctp_pkg::PERIOD_RST;
    end else if (startPulse || rin.reset || tcEvent) begin
      count_q <= period_q;
    end else if (countStep) begin
      count_q <= count_q - dctp_pkg::CNT_ONE;
    end
  end

  // Capture on rising edge of the capture input
  assign capEvent = rin.capture && !capPrev_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      capPrev_q <= 1'b0;
      capture_q <= '0;
    end else begin
      capPrev_q <= rin.capture;
      if (capEvent) begin
        capture_q <= count_q;
      end
    end
  end

  always_comb begin
    unique case (rel)
      dctp_pkg::cmp_less: cmpTrue = count_q < compare_q;
      dctp_pkg::cmp_less_or_equal: cmpTrue = count_q <= compare_q;
      dctp_pkg::cmp_equal: cmpTrue = count_q == compare_q;
      dctp_pkg::cmp_greater_or_equal: cmpTrue = count_q >= compare_q;
      dctp_pkg::cmp_greater: cmpTrue = count_q > compare_q;
      default: cmpTrue = 1'b0;
    endcase
  end

  assign cmpEvent = cmpTrue && !cmpPrev_q;
  assign events = {capEvent, cmpEvent, tcEvent};

  // Sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
      cmpPrev_q <= 1'b0;
    end else begin
      cmpPrev_q <= cmpTrue;
      if (wrEn && apbReq.paddr == dctp_pkg::ADDR_STATUS) begin
        status_q <= (status_q & ~apbReq.pwdata[dctp_pkg::ST_W-1:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
    end
  end

  // Outputs are registered; kill forces the compare-derived ones low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmpOut <= 1'b0;
      tcOut <= 1'b0;
      irq <= 1'b0;
    end else begin
      cmpOut <= cmpTrue && !rin.kill;
      if (ctrl_q[dctp_pkg::CTRL_TCSEL]) begin
        tcOut <= !cmpTrue && !rin.kill;
      end else begin
        tcOut <= tcEvent;
      end
      irq <= |(status_q & mask_q);
    end
  end

  dctp_deadband #(
    .DW(dctp_pkg::DB_W)
  ) uDb (
    .clock(clock),
    .rst_b(rst_b),
    .tick(tick),
    .pwmIn(cmpTrue && !rin.kill),
    .dbLen(deadband_q),
    .pwmHi(dbHi),
    .pwmLo(dbLo)
  );

  // Kill must hold both sides of the pair low; the gap logic alone would drive the low side
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwmHi <= 1'b0;
      pwmLo <= 1'b0;
    end else begin
      pwmHi <= dbHi && !rin.kill;
      pwmLo <= dbLo && !rin.kill;
    end
  end

  // Steps of a count, a shut gate and a status clear that the checks below build on
  sequence sTermStep;
    countStep && atTerminal && !startPulse;
  endsequence

  sequence sMidStep;
    countStep && !atTerminal && !startPulse && !rin.reset;
  endsequence

  sequence sGateShut;
    mode == dctp_pkg::MODE_GATED && !rin.enable && !rin.reset && !startPulse;
  endsequence

  sequence sOneShotEnd;
    sTermStep ##0 mode == dctp_pkg::MODE_ONESHOT;
  endsequence

  sequence sStatusClear;
    wrEn && apbReq.paddr == dctp_pkg::ADDR_STATUS;
  endsequence

  // Counter
  chk_tc_reload: assert property (
    sTermStep |=> count_q == $past(period_q))
    else $error("no reload at terminal");
  chk_count_down: assert property (
    sMidStep |=> count_q == $past(count_q) - dctp_pkg::CNT_ONE)
    else $error("bad decrement");
  chk_start_load: assert property (
    startPulse |=> count_q == $past(period_q) && run_q == dctp_pkg::RUN_COUNT)
    else $error("start did not load");
  chk_reset_load: assert property (
    rin.reset |=> count_q == $past(period_q))
    else $error("reset input did not load");

  // Run modes
  chk_oneshot_halt: assert property (
    sOneShotEnd |=> run_q == dctp_pkg::RUN_DONE)
    else $error("one shot kept running");
  chk_stopped_hold: assert property (
    run_q != dctp_pkg::RUN_COUNT && !startPulse && !rin.reset |=> count_q == $past(count_q))
    else $error("stopped counter moved");
  chk_gated_hold: assert property (
    sGateShut |=> count_q == $past(count_q))
    else $error("gated counter moved");

  // Capture and interrupt
  chk_capture_val: assert property (
    capEvent |=> capture_q == $past(count_q))
    else $error("capture wrong");
  chk_capture_flag: assert property (
    capEvent |=> status_q[dctp_pkg::ST_CAP])
    else $error("capture flag missing");
  chk_tc_flag: assert property (
    tcEvent |=> status_q[dctp_pkg::ST_TC])
    else $error("terminal flag missing");
  chk_clear_bit: assert property (
    sStatusClear ##0 apbReq.pwdata[dctp_pkg::ST_TC] && !tcEvent |=> !status_q[dctp_pkg::ST_TC])
    else $error("terminal flag not cleared");
  chk_irq_level: assert property (
    |(status_q & mask_q) |=> irq)
    else $error("irq not raised");
  chk_irq_low: assert property (
    (status_q & mask_q) == '0 |=> !irq)
    else $error("irq raised while masked");

  // Outputs
  chk_kill_outs: assert property (
    rin.kill |=> !cmpOut)
    else $error("kill ignored");
  chk_kill_pair: assert property (
    rin.kill |=> !pwmHi && !pwmLo)
    else $error("kill left the pair driven");
  chk_tc_pulse: assert property (
    !ctrl_q[dctp_pkg::CTRL_TCSEL] && tcEvent |=> tcOut)
    else $error("tc pulse missing");
  chk_cmp_compl: assert property (
    ctrl_q[dctp_pkg::CTRL_TCSEL] && !cmpTrue && !rin.kill |=> tcOut)
    else $error("complement output missing");
  chk_cmp_equal: assert property (
    rel == dctp_pkg::cmp_equal && count_q == compare_q && !rin.kill |=> cmpOut)
    else $error("equal compare missed");
  chk_cmp_false: assert property (
    !cmpTrue |=> !cmpOut)
    else $error("compare output without relation");
endmodule : dctp_timer
`default_nettype wire

// [testbench/dctp_route_model.sv]
// Routing-fabric stand-in: registers the bench's route levels and makes the count clocks.
// Assumes one clock domain; source k rises every 2**(k+1) cycles while out of reset.
`timescale 1ns/1ps
`default_nettype none
module dctp_route_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire dctp_pkg::dctp_route_in_t req,
  output logic [2:0] clkSrc,
  output logic cntEnable,
  output logic cntReset,
  output logic capTrig,
  output logic killIn
);
  logic [2:0] div_q;

  assign clkSrc = div_q;

  // Fabric is registered, so every route level lands one cycle after the bench sets it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 3'h0;
      cntEnable <= 1'b0;
      cntReset <= 1'b0;
      capTrig <= 1'b0;
      killIn <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      cntEnable <= req.enable;
      cntReset <= req.reset;
      capTrig <= req.capture;
      killIn <= req.kill;
    end
  end
endmodule : dctp_route_model
`default_nettype wire

// [testbench/dctp_timer_test.sv]
// Self-checking bench for the down-count timer: APB master tasks, one task per scenario.
// Assumes the route model in front of the routing inputs and NSRC left at 3.
`timescale 1ns/1ps
`default_nettype none
module dctp_timer_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmpOut, tcOut, pwmHi, pwmLo, irq;
  logic [2:0] clkSrc;
  logic cntEnable, cntReset, capTrig, killIn;
  dctp_pkg::dctp_route_in_t route = '0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] d, a, b;
  logic e;
  int g;

  always #20 clock = ~clock;

  dctp_route_model u_dctp_route_model (.clock(clock), .rst_b(rst_b), .req(route),
    .clkSrc(clkSrc), .cntEnable(cntEnable), .cntReset(cntReset), .capTrig(capTrig),
    .killIn(killIn));

  dctp_timer u_dctp_timer (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clkSrc(clkSrc), .cntEnable(cntEnable), .cntReset(cntReset),
    .capTrig(capTrig), .killIn(killIn), .cmpOut(cmpOut), .tcOut(tcOut), .pwmHi(pwmHi),
    .pwmLo(pwmLo), .irq(irq));

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Budget is about thirty times the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, ad, wd, x, y);
  endtask : wr

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] r,
      input logic [1:0] k, input logic t, input logic s);
    return {23'h000000, t, k, r, m, s};
  endfunction : cfg

  task automatic tc_gap(output int gap);
    while (tcOut !== 1'b1) @(posedge clock);
    @(posedge clock);
    gap = 1;
    while (tcOut !== 1'b1) begin
      @(posedge clock);
      gap++;
    end
  endtask : tc_gap

  task automatic t_reset();
    apb(1'b0, dctp_pkg::ADDR_PERIOD, 32'h0, d, e);
    check(d, 32'h0000FFFF, "period reset");
    apb(1'b0, dctp_pkg::ADDR_COMPARE, 32'h0, d, e);
    check(d, 32'h00008000, "compare reset");
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, d, e);
    check(d, 32'h0000FFFF, "count reset");
    apb(1'b0, 8'h24, 32'h0, d, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    check(d, 32'h0, "unmapped data");
    $display("done: reset values");
  endtask : t_reset

  task automatic t_period_clock();
    wr(dctp_pkg::ADDR_PERIOD, 32'h4);
    wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_FREE, 3'h0, 2'h0, 1'b0, 1'b1));
    tc_gap(g);
    check(32'(g), 32'h5, "free period");
    wr(dctp_pkg::ADDR_PERIOD, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_FREE, 3'h0, 2'(k + 1), 1'b0, 1'b1));
      tc_gap(g);
      tc_gap(g);
      check(32'(g), 32'(3 * (2 << k)), "source period");
    end
    $display("done: period and clock select");
  endtask : t_period_clock

  task automatic t_modes();
    wr(dctp_pkg::ADDR_PERIOD, 32'h3);
    wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_ONESHOT, 3'h0, 2'h0, 1'b0, 1'b1));
    repeat (20) @(posedge clock);
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, a, e);
    repeat (10) @(posedge clock);
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, b, e);
    check(b, a, "one shot halted");
    check(a, 32'h3, "one shot parked on reload");
    wr(dctp_pkg::ADDR_PERIOD, 32'h1000);
    wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_GATED, 3'h0, 2'h0, 1'b0, 1'b1));
    repeat (5) @(posedge clock);
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, a, e);
    check(a, 32'h1000, "start reload");
    repeat (10) @(posedge clock);
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, b, e);
    check(b, a, "gate closed");
    route.enable <= 1'b1;
    repeat (10) @(posedge clock);
    route.enable <= 1'b0;
    apb(1'b0, dctp_pkg::ADDR_COUNT, 32'h0, d, e);
    check(d, b - 32'hA, "counts down");
    $display("done: run modes");
  endtask : t_modes

  task automatic t_compare();
    logic x;
    wr(dctp_pkg::ADDR_PERIOD, 32'h5);
    wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_FREE, 3'h0, 2'h0, 1'b1, 1'b1));
    route.reset <= 1'b1;
    for (int r = 4; r >= 0; r--) begin
      for (int c = 4; c <= 6; c++) begin
        wr(dctp_pkg::ADDR_COMPARE, 32'(c));
        wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_FREE, 3'(r), 2'h0, 1'b1, 1'b0));
        repeat (4) @(posedge clock);
        case (r)
          0: x = 5 < c;
          1: x = 5 <= c;
          2: x = 5 == c;
          3: x = 5 >= c;
          default: x = 5 > c;
        endcase
        check({31'h0, cmpOut}, {31'h0, x}, "relation");
        check({31'h0, tcOut}, {31'h0, ~x}, "complement");
      end
    end
    route.kill <= 1'b1;
    repeat (4) @(posedge clock);
    check({29'h0, cmpOut, tcOut, pwmHi | pwmLo}, 32'h0, "kill");
    route.kill <= 1'b0;
    $display("done: compare and kill");
  endtask : t_compare

  task automatic t_irq();
    wr(dctp_pkg::ADDR_MASK, 32'h4);
    wr(dctp_pkg::ADDR_STATUS, 32'h7);
    route.capture <= 1'b1;
    @(posedge clock);
    route.capture <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b0, dctp_pkg::ADDR_CAPTURE, 32'h0, d, e);
    check(d, 32'h5, "capture value");
    check({31'h0, irq}, 32'h1, "capture irq");
    wr(dctp_pkg::ADDR_STATUS, 32'h4);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0, "irq cleared");
    route.reset <= 1'b0;
    // Compare inside the count range so the relation rises every period
    wr(dctp_pkg::ADDR_COMPARE, 32'h3);
    for (int s = 0; s < 2; s++) begin
      wr(dctp_pkg::ADDR_MASK, 32'(1 << s));
      repeat (20) @(posedge clock);
      check({31'h0, irq}, 32'h1, "tc or compare irq");
    end
    wr(dctp_pkg::ADDR_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0, "masked irq");
    $display("done: capture and interrupt");
  endtask : t_irq

  task automatic t_deadband();
    int run, minRun, hi, ov;
    run = 0;
    minRun = 999;
    hi = 0;
    ov = 0;
    wr(dctp_pkg::ADDR_PERIOD, 32'h9);
    wr(dctp_pkg::ADDR_COMPARE, 32'h5);
    wr(dctp_pkg::ADDR_DEADBAND, 32'h3);
    wr(dctp_pkg::ADDR_CTRL, cfg(dctp_pkg::MODE_FREE, 3'h0, 2'h0, 1'b0, 1'b1));
    repeat (80) begin
      @(posedge clock);
      ov += int'(pwmHi === 1'b1 && pwmLo === 1'b1);
      hi += int'(pwmHi === 1'b1);
      if (pwmHi === 1'b0 && pwmLo === 1'b0) begin
        run++;
      end else begin
        if (run > 0 && run < minRun) minRun = run;
        run = 0;
      end
    end
    check(32'(ov), 32'h0, "pair overlap");
    check({31'h0, hi > 0 && minRun >= 3}, 32'h1, "dead gap");
    $display("done: deadband");
  endtask : t_deadband

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_period_clock();
    t_modes();
    t_compare();
    t_irq();
    t_deadband();
    print_verdict();
  end
endmodule : dctp_timer_test
`default_nettype wire
